//--- logic/dod_directional_overcurrent_function.sv
// directional decision front end with magnitude overcurrent stage
// --------------------------------------------------------------------------
// Summary of operation
// RL1 - pick lowest impedance loop, forward its quantities
// RL2 - loop usable needs U over 5%, I 8%
// RL3 - isolated network: phase-to-phase loops only
// RL4 - network setting solid or isolated, solid default
// RL5 - enable flag needs voltage and current minimums
// RL6 - angle of loop voltage against loop current
// RL7 - direction ok needs enable and angle inside window
// RL8 - direction setting none/forward/backward, forward default
// RL9 - weak loop voltage: polarize by positive sequence
// RL10 - weak positive sequence: polarize by stored voltage
// RL11 - switch onto fault forces direction ok, no delay
// RL12 - supervision fail with fallback: go non-directional
// RL13 - supervision fail without fallback: block function
// RL14 - operating angle 10 to 85, default 60
// RL15 - characteristic angle -90 to 90, default 60
// RL16 - disabled function asserts no start or trip
// RL17 - three phase starts, general start, trip outputs
// RL18 - rms or fundamental currents feed overcurrent stage
// RL19 - start and trip only while direction ok
// RL20 - current select defaults to fundamental
// RL21 - block input suppresses all operation; code blocks starts and trip only, not direction_ok
// RL22 - window is characteristic plus/minus operating angle
// --------------------------------------------------------------------------
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dod_directional_overcurrent_function #(
  parameter int TRIP_CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic meas_valid,
  input wire dod_pkg::dod_loop_t [dod_pkg::NUM_LOOPS-1:0] loop_meas,
  input wire dod_pkg::dod_pos_t pos_seq,
  input wire logic [2:0][dod_pkg::MAG_W-1:0] i_fund,
  input wire logic [2:0][dod_pkg::MAG_W-1:0] i_rms,
  input wire logic block_in,
  input wire logic voltage_supervision_fail,
  input wire logic switch_onto_fault_condition,
  output logic [2:0] start_phase,
  output logic general_start,
  output logic trip,
  output logic direction_ok
);
  import dod_pkg::*;

  if (TRIP_CNT_W < 1 || TRIP_CNT_W > 16) begin : g_bad_width
    $error("TRIP_CNT_W must lie in 1..16");
  end

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic above_pct(input logic [MAG_W-1:0] mag,
                                     input logic [MAG_W-1:0] rated,
                                     input logic [7:0] pct,
                                     input logic or_equal);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = mag * PCT_FULL;
    rhs = rated * pct;
    above_pct = or_equal ? (lhs >= rhs) : (lhs > rhs);
  endfunction : above_pct

  // one step suffices: inputs never leave -540..539
  function automatic logic signed [11:0] wrap(input logic signed [11:0] x);
    logic signed [11:0] y;
    y = x;
    if (y >= ANG_HALF_TURN) begin
      y = y - ANG_FULL_TURN;
    end else if (y < -ANG_HALF_TURN) begin
      y = y + ANG_FULL_TURN;
    end
    wrap = y;
  endfunction : wrap

  function automatic logic in_window(input logic signed [11:0] d,
                                     input logic [6:0] op);
    logic signed [11:0] a;
    a = (d < 0) ? -d : d;
    in_window = a <= $signed({5'h00, op});
  endfunction : in_window

  // --------------------------------------------------------------------------
  // configuration registers and apb slave
  // --------------------------------------------------------------------------
  logic en_reg, en_next;
  logic iso_reg, iso_next;
  dod_dir_t dir_reg, dir_next;
  logic fallback_reg, fallback_next;
  logic rms_reg, rms_next;
  logic [6:0] op_ang_reg, op_ang_next;
  logic signed [7:0] char_ang_reg, char_ang_next;
  logic [MAG_W-1:0] rated_u_reg, rated_u_next;
  logic [MAG_W-1:0] rated_i_reg, rated_i_next;
  logic [MAG_W-1:0] start_cur_reg, start_cur_next;
  logic [15:0] delay_reg, delay_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] status_word;
  logic signed [11:0] phi;
  logic mapped, wr_take;
  logic signed [7:0] wr_char;
  logic [6:0] wr_op;
  logic [1:0] wr_dir;

  always_comb begin
    mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_ANGLE) ||
             (paddr == ADDR_RATED) || (paddr == ADDR_START) ||
             (paddr == ADDR_DELAY) || (paddr == ADDR_STATUS) ||
             (paddr == ADDR_LOOP_ANGLE);
    // one wait state; write lands on the edge that samples pready
    wr_take = psel && penable && pready_reg && pwrite && mapped;
    pready_next = psel && penable && !pready_reg;
    pslverr_next = pready_next && !mapped;
    wr_op = pwdata[ANG_OP_LSB +: 7];
    wr_char = pwdata[ANG_CHAR_LSB +: 8];
    wr_dir = pwdata[CTRL_DIR_LSB +: 2];
    en_next = en_reg;
    iso_next = iso_reg;
    dir_next = dir_reg;
    fallback_next = fallback_reg;
    rms_next = rms_reg;
    op_ang_next = op_ang_reg;
    char_ang_next = char_ang_reg;
    rated_u_next = rated_u_reg;
    rated_i_next = rated_i_reg;
    start_cur_next = start_cur_reg;
    delay_next = delay_reg;
    if (wr_take) begin
      case (paddr)
        ADDR_CTRL: begin
          en_next = pwdata[CTRL_EN_BIT]; // RL16
          iso_next = pwdata[CTRL_ISO_BIT]; // RL4
          if (wr_dir != 2'h3) begin
            dir_next = dod_dir_t'(wr_dir); // RL8
          end
          fallback_next = pwdata[CTRL_FALLBACK_BIT];
          rms_next = pwdata[CTRL_RMS_BIT]; // RL18
        end
        ADDR_ANGLE: begin
          // out-of-range fields keep their old value
          if (wr_op >= OP_ANG_MIN && wr_op <= OP_ANG_MAX) begin
            op_ang_next = wr_op; // RL14
          end
          if (wr_char >= CHAR_ANG_MIN && wr_char <= CHAR_ANG_MAX) begin
            char_ang_next = wr_char; // RL15
          end
        end
        ADDR_RATED: begin
          rated_u_next = pwdata[RATED_U_LSB +: MAG_W];
          rated_i_next = pwdata[RATED_I_LSB +: MAG_W];
        end
        ADDR_START: begin
          start_cur_next = pwdata[MAG_W-1:0];
        end
        ADDR_DELAY: begin
          delay_next = pwdata[15:0];
        end
        default: begin
        end
      endcase
    end
    prdata_next = prdata_reg;
    if (pready_next) begin
      case (paddr)
        ADDR_CTRL: prdata_next = {26'h0, rms_reg, fallback_reg,
                                  dir_reg, iso_reg, en_reg};
        ADDR_ANGLE: prdata_next = {8'h00, char_ang_reg, 9'h000, op_ang_reg};
        ADDR_RATED: prdata_next = {rated_i_reg, rated_u_reg};
        ADDR_START: prdata_next = {16'h0000, start_cur_reg};
        ADDR_DELAY: prdata_next = {16'h0000, delay_reg};
        ADDR_STATUS: prdata_next = status_word;
        ADDR_LOOP_ANGLE: prdata_next = {{20{phi[11]}}, phi};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= CTRL_EN_RST;
      iso_reg <= CTRL_ISO_RST;
      dir_reg <= DOD_FORWARD;
      fallback_reg <= CTRL_FALLBACK_RST;
      rms_reg <= CTRL_RMS_RST; // RL20
      op_ang_reg <= OP_ANG_RST;
      char_ang_reg <= CHAR_ANG_RST;
      rated_u_reg <= RATED_U_RST;
      rated_i_reg <= RATED_I_RST;
      start_cur_reg <= START_CUR_RST;
      delay_reg <= TRIP_DELAY_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
      iso_reg <= iso_next;
      dir_reg <= dir_next;
      fallback_reg <= fallback_next;
      rms_reg <= rms_next;
      op_ang_reg <= op_ang_next;
      char_ang_reg <= char_ang_next;
      rated_u_reg <= rated_u_next;
      rated_i_reg <= rated_i_next;
      start_cur_reg <= start_cur_next;
      delay_reg <= delay_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // --------------------------------------------------------------------------
  // measurement snapshot and pre-fault voltage memory
  // --------------------------------------------------------------------------
  dod_loop_t [NUM_LOOPS-1:0] loops_reg, loops_next;
  dod_pos_t pos_reg, pos_next;
  logic [2:0][MAG_W-1:0] cur_reg, cur_next;
  logic signed [NUM_LOOPS-1:0][ANG_W-1:0] mem_ang_reg, mem_ang_next;
  logic [NUM_LOOPS-1:0] mem_ok_reg, mem_ok_next;

  always_comb begin
    loops_next = loops_reg;
    pos_next = pos_reg;
    cur_next = cur_reg;
    mem_ang_next = mem_ang_reg;
    mem_ok_next = mem_ok_reg;
    if (meas_valid) begin
      loops_next = loop_meas;
      pos_next = pos_seq;
      cur_next = rms_reg ? i_rms : i_fund; // RL18
      // healthy voltages refresh the memory used during close-up faults
      for (int k = 0; k < NUM_LOOPS; k++) begin
        if (above_pct(loop_meas[k].u_mag, rated_u_reg, U_MIN_PCT, 1'b0)) begin
          mem_ang_next[k] = loop_meas[k].u_ang; // RL10
          mem_ok_next[k] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loops_reg <= '0;
      pos_reg <= '0;
      cur_reg <= '0;
      mem_ang_reg <= '0;
      mem_ok_reg <= '0;
    end else begin
      loops_reg <= loops_next;
      pos_reg <= pos_next;
      cur_reg <= cur_next;
      mem_ang_reg <= mem_ang_next;
      mem_ok_reg <= mem_ok_next;
    end
  end

  // --------------------------------------------------------------------------
  // loop selection, polarization, angle and direction
  // --------------------------------------------------------------------------
  logic [NUM_LOOPS-1:0] u_ok, i_ok;
  logic [2:0] best;
  logic found, pos_ok, enable_flag, fwd_in, bwd_in, dir_ok_c;
  dod_pol_t pol;
  logic signed [ANG_W-1:0] pol_ang;
  dod_dir_t eff_dir;

  always_comb begin
    best = 3'h0;
    found = 1'b0;
    for (int k = 0; k < NUM_LOOPS; k++) begin
      u_ok[k] = above_pct(loops_reg[k].u_mag, rated_u_reg, U_MIN_PCT,
                          1'b0); // RL2
      i_ok[k] = above_pct(loops_reg[k].i_mag, rated_i_reg, I_MIN_PCT,
                          1'b1); // RL2
      // compare U/I by cross products to avoid a divider
      if (i_ok[k] && !(iso_reg && k >= NUM_PP_LOOPS)) begin // RL3
        if (!found || (32'(loops_reg[k].u_mag) * loops_reg[best].i_mag <
                       32'(loops_reg[best].u_mag) * loops_reg[k].i_mag)) begin
          best = 3'(k); // RL1
          found = 1'b1;
        end
      end
    end
    pos_ok = above_pct(pos_reg.mag, rated_u_reg, U_MIN_PCT, 1'b0);
    if (u_ok[best]) begin
      pol = DOD_POL_LOOP;
      pol_ang = loops_reg[best].u_ang; // RL1
    end else if (pos_ok) begin
      pol = DOD_POL_POS_SEQ; // RL9
      pol_ang = pos_reg.ang;
    end else if (mem_ok_reg[best]) begin
      pol = DOD_POL_MEMORY; // RL10
      pol_ang = mem_ang_reg[best];
    end else begin
      pol = DOD_POL_NONE;
      pol_ang = loops_reg[best].u_ang;
    end
    // substitutes count as sufficient voltage for the enable flag
    enable_flag = found && i_ok[best] && (pol != DOD_POL_NONE); // RL5
    phi = wrap(12'(pol_ang) - 12'(loops_reg[best].i_ang)); // RL6
    fwd_in = in_window(wrap(phi - 12'(char_ang_reg)), op_ang_reg); // RL22
    bwd_in = in_window(wrap(phi - 12'(char_ang_reg) - ANG_HALF_TURN),
                       op_ang_reg); // RL22
    eff_dir = (voltage_supervision_fail && fallback_reg) ?
              DOD_NO_DIRECTION_CHECK : dir_reg; // RL12
    case (eff_dir)
      DOD_FORWARD: dir_ok_c = enable_flag && fwd_in; // RL7
      DOD_BACKWARD: dir_ok_c = enable_flag && bwd_in; // RL7
      DOD_NO_DIRECTION_CHECK: dir_ok_c = 1'b1; // RL8
      default: dir_ok_c = 1'b0;
    endcase
    if (switch_onto_fault_condition) begin
      dir_ok_c = 1'b1; // RL11
    end
  end

  // --------------------------------------------------------------------------
  // magnitude overcurrent stage and outputs
  // --------------------------------------------------------------------------
  logic operate;
  logic [2:0] start_next, start_reg;
  logic gstart_next, gstart_reg;
  logic trip_next, trip_reg;
  logic dir_ok_reg;
  logic [TRIP_CNT_W-1:0] cnt_next, cnt_reg;
  logic [2:0] loop_reg;
  dod_pol_t pol_reg;
  logic enable_reg;

  always_comb begin
    operate = en_reg && !block_in && // RL16 RL21
              !(voltage_supervision_fail && !fallback_reg); // RL13
    for (int p = 0; p < 3; p++) begin
      start_next[p] = operate && dir_ok_c &&
                      (cur_reg[p] > start_cur_reg); // RL19
    end
    gstart_next = |start_next; // RL17
    cnt_next = cnt_reg;
    if (!gstart_next) begin
      cnt_next = '0;
    end else if (meas_valid && (cnt_reg != {TRIP_CNT_W{1'b1}})) begin
      cnt_next = cnt_reg + 1'b1;
    end
    // switch onto fault bypasses the definite delay
    trip_next = gstart_next && (switch_onto_fault_condition || // RL11
                32'(cnt_reg) >= 32'(delay_reg)); // RL19
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 3'h0;
      gstart_reg <= 1'b0;
      trip_reg <= 1'b0;
      dir_ok_reg <= 1'b0;
      cnt_reg <= '0;
      loop_reg <= 3'h0;
      pol_reg <= DOD_POL_NONE;
      enable_reg <= 1'b0;
    end else begin
      start_reg <= start_next;
      gstart_reg <= gstart_next;
      trip_reg <= trip_next;
      dir_ok_reg <= dir_ok_c;
      cnt_reg <= cnt_next;
      loop_reg <= best;
      pol_reg <= pol;
      enable_reg <= enable_flag;
    end
  end

  assign status_word = {19'h0, trip_reg, gstart_reg, start_reg, 1'b0,
                        pol_reg, loop_reg, enable_reg, dir_ok_reg};
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign start_phase = start_reg;
  assign general_start = gstart_reg;
  assign trip = trip_reg;
  assign direction_ok = dir_ok_reg;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  sequence s_fault_sotf;
    switch_onto_fault_condition && operate;
  endsequence

  property p_disabled_quiet;
    @(posedge pclk) disable iff (!presetn)
      !en_reg |=> (start_phase == 3'h0) && !trip;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // RL16
    else $error("start or trip while disabled");

  property p_block_quiet;
    @(posedge pclk) disable iff (!presetn)
      block_in |=> !general_start && !trip;
  endproperty
  a_block_quiet: assert property (p_block_quiet) // RL21
    else $error("output while block input active");

  property p_vts_block;
    @(posedge pclk) disable iff (!presetn)
      voltage_supervision_fail && !fallback_reg |=> !general_start;
  endproperty
  a_vts_block: assert property (p_vts_block) // RL13
    else $error("supervision fail did not block");

  property p_vts_no_direction_check;
    @(posedge pclk) disable iff (!presetn)
      voltage_supervision_fail && fallback_reg |=> direction_ok;
  endproperty
  a_vts_no_direction_check: assert property (p_vts_no_direction_check) // RL12
    else $error("fallback did not turn non-directional");

  property p_sotf_fast;
    @(posedge pclk) disable iff (!presetn)
      s_fault_sotf ##0 (cur_reg[0] > start_cur_reg) |=> direction_ok && trip;
  endproperty
  a_sotf_fast: assert property (p_sotf_fast) // RL11
    else $error("switch onto fault not immediate");

  property p_no_direction_check_ok;
    @(posedge pclk) disable iff (!presetn)
      dir_reg == DOD_NO_DIRECTION_CHECK |=> direction_ok;
  endproperty
  a_no_direction_check_ok: assert property (p_no_direction_check_ok) // RL8
    else $error("non-directional setting lost direction ok");

  property p_start_needs_dir;
    @(posedge pclk) disable iff (!presetn)
      (general_start || trip) |-> direction_ok && (start_phase != 3'h0);
  endproperty
  a_start_needs_dir: assert property (p_start_needs_dir) // RL19
    else $error("start without direction ok");

  property p_iso_loops;
    @(posedge pclk) disable iff (!presetn)
      iso_reg && $past(iso_reg) |-> loop_reg < 3'h3;
  endproperty
  a_iso_loops: assert property (p_iso_loops) // RL3
    else $error("phase-to-neutral loop chosen in isolated network");

  property p_angle_limits;
    @(posedge pclk) disable iff (!presetn)
      op_ang_reg >= OP_ANG_MIN && op_ang_reg <= OP_ANG_MAX &&
      char_ang_reg >= CHAR_ANG_MIN && char_ang_reg <= CHAR_ANG_MAX;
  endproperty
  a_angle_limits: assert property (p_angle_limits) // RL14 RL15
    else $error("angle setting out of range");

  property p_dir_needs_enable;
    @(posedge pclk) disable iff (!presetn)
      dir_reg != DOD_NO_DIRECTION_CHECK && !switch_onto_fault_condition &&
      !voltage_supervision_fail && !enable_flag |=> !direction_ok;
  endproperty
  a_dir_needs_enable: assert property (p_dir_needs_enable) // RL7
    else $error("direction ok without enable flag");
endmodule : dod_directional_overcurrent_function
`default_nettype wire

//--- shared/dod_pkg.sv
// constants, carriers and register map of the directional overcurrent block
`default_nettype none
package dod_pkg;
  // ----------------------------------------------------------------------
  // widths and carriers
  // ----------------------------------------------------------------------
  localparam int MAG_W = 16;
  localparam int ANG_W = 10;
  localparam int NUM_LOOPS = 6;
  localparam int NUM_PP_LOOPS = 3;

  typedef struct packed {
    logic [MAG_W-1:0] u_mag;
    logic [MAG_W-1:0] i_mag;
    logic signed [ANG_W-1:0] u_ang;
    logic signed [ANG_W-1:0] i_ang;
  } dod_loop_t;

  typedef struct packed {
    logic [MAG_W-1:0] mag;
    logic signed [ANG_W-1:0] ang;
  } dod_pos_t;

  typedef enum logic [1:0] {
    DOD_NO_DIRECTION_CHECK = 2'h0,
    DOD_FORWARD = 2'h1,
    DOD_BACKWARD = 2'h2
  } dod_dir_t;

  typedef enum logic [1:0] {
    DOD_POL_LOOP = 2'h0,
    DOD_POL_POS_SEQ = 2'h1,
    DOD_POL_MEMORY = 2'h2,
    DOD_POL_NONE = 2'h3
  } dod_pol_t;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_ANGLE = 12'h004;
  localparam logic [11:0] ADDR_RATED = 12'h008;
  localparam logic [11:0] ADDR_START = 12'h00c;
  localparam logic [11:0] ADDR_DELAY = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_LOOP_ANGLE = 12'h018;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ISO_BIT = 1;
  localparam int CTRL_DIR_LSB = 2;
  localparam int CTRL_FALLBACK_BIT = 4;
  localparam int CTRL_RMS_BIT = 5;
  localparam int ANG_OP_LSB = 0;
  localparam int ANG_CHAR_LSB = 16;
  localparam int RATED_U_LSB = 0;
  localparam int RATED_I_LSB = 16;
  localparam int ST_DIR_OK_BIT = 0;
  localparam int ST_ENABLE_BIT = 1;
  localparam int ST_LOOP_LSB = 2;
  localparam int ST_POL_LSB = 5;
  localparam int ST_START_LSB = 8;
  localparam int ST_GSTART_BIT = 11;
  localparam int ST_TRIP_BIT = 12;

  // ----------------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------------
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic CTRL_ISO_RST = 1'h0;
  localparam logic CTRL_FALLBACK_RST = 1'h0;
  localparam logic CTRL_RMS_RST = 1'h0;
  localparam logic [6:0] OP_ANG_RST = 7'h3c;
  localparam logic [6:0] OP_ANG_MIN = 7'h0a;
  localparam logic [6:0] OP_ANG_MAX = 7'h55;
  localparam logic signed [7:0] CHAR_ANG_RST = 8'sh3c;
  localparam logic signed [7:0] CHAR_ANG_MIN = -8'sh5a;
  localparam logic signed [7:0] CHAR_ANG_MAX = 8'sh5a;
  localparam logic [MAG_W-1:0] RATED_U_RST = 16'h1000;
  localparam logic [MAG_W-1:0] RATED_I_RST = 16'h1000;
  localparam logic [MAG_W-1:0] START_CUR_RST = 16'h1000;
  localparam logic [15:0] TRIP_DELAY_RST = 16'h0010;

  // ----------------------------------------------------------------------
  // magnitude thresholds (percent of rated) and angle constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] U_MIN_PCT = 8'h05;
  localparam logic [7:0] I_MIN_PCT = 8'h08;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic signed [11:0] ANG_HALF_TURN = 12'sh0b4;
  localparam logic signed [11:0] ANG_FULL_TURN = 12'sh168;
endpackage : dod_pkg
`default_nettype wire

//--- bench/dod_meas_source.sv
// measurement source model: one snapshot per request
`timescale 1ns/1ps
`default_nettype none
module dod_meas_source (
  input wire logic pclk,
  input wire logic fire,
  input wire logic signed [dod_pkg::ANG_W-1:0] angle,
  input wire logic [dod_pkg::MAG_W-1:0] cur_f,
  input wire logic [dod_pkg::MAG_W-1:0] cur_r,
  output logic meas_valid,
  output dod_pkg::dod_loop_t [dod_pkg::NUM_LOOPS-1:0] loop_meas,
  output dod_pkg::dod_pos_t pos_seq,
  output logic [2:0][dod_pkg::MAG_W-1:0] i_fund,
  output logic [2:0][dod_pkg::MAG_W-1:0] i_rms
);
  import dod_pkg::*;
  initial begin
    meas_valid = 1'b0;
    loop_meas = '0;
    pos_seq = '0;
    i_fund = '0;
    i_rms = '0;
  end
  // ------------------------------------------------------------------
  // snapshot drive
  // ------------------------------------------------------------------
  // values are scrambled between pulses so a late sample shows up
  always @(posedge pclk) begin
    meas_valid <= fire;
    if (fire) begin
      for (int n = 0; n < NUM_LOOPS; n++) begin
        loop_meas[n] <= '{(n < 3) ? 16'h0400 : 16'h0200, 16'h0400, angle,
                          10'sh000};
      end
      pos_seq <= '{16'h0800, 10'sh000};
      i_fund <= {3{cur_f}};
      i_rms <= {3{cur_r}};
    end else begin
      loop_meas <= ~loop_meas;
      pos_seq <= ~pos_seq;
      i_fund <= ~i_fund;
      i_rms <= ~i_rms;
    end
  end
endmodule : dod_meas_source
`default_nettype wire

//--- bench/directional_overcurrent_decision_test.sv
// self-checking bench for the directional overcurrent block
`timescale 1ns/1ps
`default_nettype none
module directional_overcurrent_decision_test;
  import dod_pkg::*;
  typedef struct packed {
    logic [1:0] dir;
    logic signed [9:0] ang;
    logic ok;
  } dod_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, fire = 1'b0, blk = 1'b0, vfail = 1'b0, sotf = 1'b0;
  logic pready, pslverr, meas_valid, err, general_start, trip, dir_ok;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic signed [9:0] ang = 10'sh000;
  logic [15:0] cur_f = 16'h2000, cur_r = 16'h0100;
  dod_loop_t [NUM_LOOPS-1:0] loop_meas;
  dod_pos_t pos_seq;
  logic [2:0][MAG_W-1:0] i_fund, i_rms;
  logic [2:0] start_phase;
  logic [5:0] outs;
  int bad_count = 0, check_count = 0, cycles = 0;
  dod_row_t rows [10] = '{'{2'h1, 10'sh03c, 1'b1}, '{2'h1, 10'sh078, 1'b1},
    '{2'h1, 10'sh079, 1'b0}, '{2'h1, 10'sh000, 1'b1},
    '{2'h1, -10'sh001, 1'b0}, '{2'h2, -10'sh078, 1'b1},
    '{2'h2, 10'sh03c, 1'b0}, '{2'h2, -10'sh03c, 1'b1},
    '{2'h2, -10'sh03b, 1'b0}, '{2'h0, -10'sh078, 1'b1}};
  assign outs = {start_phase, general_start, trip, dir_ok};
  always #12.5 pclk = ~pclk;
  dod_meas_source src_u (.pclk(pclk), .fire(fire), .angle(ang),
    .cur_f(cur_f), .cur_r(cur_r), .meas_valid(meas_valid),
    .loop_meas(loop_meas), .pos_seq(pos_seq), .i_fund(i_fund),
    .i_rms(i_rms));
  dod_directional_overcurrent_function dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas_valid(meas_valid), .loop_meas(loop_meas),
    .pos_seq(pos_seq), .i_fund(i_fund), .i_rms(i_rms), .block_in(blk),
    .voltage_supervision_fail(vfail), .switch_onto_fault_condition(sotf),
    .start_phase(start_phase), .general_start(general_start), .trip(trip),
    .direction_ok(dir_ok));
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic meas(input logic signed [9:0] a);
    ang <= a;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : meas
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // limit guards every wait, including an apb answer that never comes
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      bad_count++;
      report_and_stop;
    end
  end
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl", rd, 32'h5);
    apb(1'b0, ADDR_ANGLE, 32'h0);
    check("angle", rd, 32'h003c003c);
    apb(1'b1, ADDR_ANGLE, 32'h003c0055);
    apb(1'b1, ADDR_ANGLE, 32'h005b0009);
    apb(1'b0, ADDR_ANGLE, 32'h0);
    check("angle", rd, 32'h003c0055);
    apb(1'b0, 12'h01c, 32'h0);
    check("slverr", err, 32'h1);
    apb(1'b1, ADDR_ANGLE, 32'h003c003c);
    apb(1'b1, ADDR_DELAY, 32'h0);
    foreach (rows[k]) begin
      apb(1'b1, ADDR_CTRL, {28'h0, rows[k].dir, 2'b01});
      meas(rows[k].ang);
      check("outputs", outs, {6{rows[k].ok}});
    end
    apb(1'b1, ADDR_CTRL, 32'h5);
    blk <= 1'b1;
    meas(10'sh03c);
    check("blocked", outs, 32'h1);
    blk <= 1'b0;
    sotf <= 1'b1;
    meas(-10'sh03c);
    check("sotf", outs, 32'h3f);
    sotf <= 1'b0;
    vfail <= 1'b1;
    meas(10'sh03c);
    check("vfail", outs, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h15);
    meas(-10'sh03c);
    check("fallback", outs, 32'h3f);
    vfail <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h4);
    meas(10'sh03c);
    check("disabled", outs, 32'h1);
    cur_f <= 16'h0100;
    cur_r <= 16'h2000;
    apb(1'b1, ADDR_CTRL, 32'h25);
    meas(10'sh03c);
    check("rms", outs, 32'h3f);
    apb(1'b1, ADDR_CTRL, 32'h5);
    meas(10'sh03c);
    check("fund", outs, 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("loop", rd[ST_LOOP_LSB +: 3], 32'h3);
    apb(1'b1, ADDR_CTRL, 32'h7);
    meas(10'sh03c);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("iso loop", rd[ST_LOOP_LSB +: 3], 32'h0);
    cur_f <= 16'h2000;
    apb(1'b1, ADDR_DELAY, 32'h2);
    repeat (2) begin
      meas(10'sh03c);
      check("delay", outs, 32'h3d);
    end
    meas(10'sh03c);
    check("delay", outs, 32'h3f);
    presetn <= 1'b0;
    @(posedge pclk);
    check("reset", outs, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ADDR_DELAY, 32'h0);
    check("delay reset", rd, 32'(TRIP_DELAY_RST));
    check("after reset", outs, 32'h0);
    report_and_stop;
  end
endmodule : directional_overcurrent_decision_test
`default_nettype wire
